// [verif/pcb_host_model.sv]
// Behavioural host memory controller driving the link pins.
// Assumes the bench resolves the shared data and strobe wires.
module pcb_host_model (
	input wire logic clock,
	output logic cs_n,
	output logic link_ck,
	output logic [7:0] host_dq,
	input wire logic [7:0] dq_out,
	input wire logic read_write_data_strobe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] got [$];

	initial begin
		cs_n = 1'b1;
		link_ck = 1'b0;
		host_dq = 8'h00;
	end

	// Each entry holds strobe and byte answered to one link edge after CA.
	task automatic xfer(input logic [47:0] ca, input logic [15:0] wd,
		input int nh);
		got.delete();
		cs_n <= 1'b0;
		host_dq <= ca[47:40];
		repeat (6) @(posedge clock);
		for (int h = 0; h <= 6 + nh; h++) begin
			if (h < 6 + nh)
				link_ck <= ~link_ck;
			repeat (2) @(posedge clock);
			if (h > 6)
				got.push_back({read_write_data_strobe_out, dq_out});
			if (h < 5)
				host_dq <= ca[39 - 8 * h -: 8];
			else
				host_dq <= h == 5 ? wd[15:8] : wd[7:0];
			repeat (2) @(posedge clock);
		end
		cs_n <= 1'b1;
		host_dq <= ~host_dq;
		repeat (8) @(posedge clock);
	endtask

	task automatic cs_pulse();
		cs_n <= 1'b0;
		repeat (8) @(posedge clock);
		cs_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
endmodule

// [verif/pcb_seq_assertions.sv]
// Checker for the configuration register and burst sequencer.
// Bound to pcb_sequencer and sees only its ports.
module pcb_seq_assertions
	import pcb_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic refresh_pending,
	input wire logic dq_oe,
	input wire logic read_write_data_strobe_out,
	input wire logic read_write_data_strobe_oe,
	input wire pcb_array_req_type array_req,
	input wire pcb_config_type config_out,
	input wire logic [7:0] drive_ohms,
	input wire logic deep_power_down_state
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] OHMS [8] = '{8'h22, 8'h73, 8'h43, 8'h2e, 8'h22,
		8'h1b, 8'h16, 8'h13};
	localparam logic [5:0] GM [4] = '{PCB_MASK_128, PCB_MASK_64,
		PCB_MASK_16, PCB_MASK_32};
	logic [31:0] last_reg;
	logic seen_reg;
	logic [31:0] grp_mask;
	assign grp_mask = {26'h0, GM[config_out.burst_length]};
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// The first strobe of a frame has no predecessor to compare with.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			seen_reg <= 1'b0;
			last_reg <= 32'h0;
		end else if (cs_n) begin
			seen_reg <= 1'b0;
		end else if (array_req.read_strobe) begin
			seen_reg <= 1'b1;
			last_reg <= array_req.addr;
		end
	end

	sequence s_cs_idle;
		cs_n [*5];
	endsequence
	sequence s_ca_start;
		$rose(read_write_data_strobe_oe);
	endsequence
	property p_reset_defaults;
		$rose(resetn) |-> config_out == PCB_CONFIG_RESET;
	endproperty
	property p_drive_table;
		drive_ohms == OHMS[config_out.drive_code];
	endproperty
	property p_config_frozen;
		(!cs_n) [*6] |-> $stable(config_out);
	endproperty
	property p_dpd_entry;
		$fell(config_out.normal_power) |-> ##[0:1] deep_power_down_state;
	endproperty
	property p_fixed_refresh;
		s_ca_start ##0 config_out.fixed_latency |-> read_write_data_strobe_out;
	endproperty
	property p_variable_refresh;
		s_ca_start ##0 !config_out.fixed_latency |-> read_write_data_strobe_out == refresh_pending;
	endproperty
	property p_oe_release;
		s_cs_idle |-> !dq_oe && !read_write_data_strobe_oe;
	endproperty
	property p_wrap_stay;
		array_req.read_strobe && seen_reg && config_out.legacy_wrap |->
			array_req.addr == ((last_reg & ~grp_mask) |
			((last_reg + 32'h1) & grp_mask));
	endproperty

	a_reset_defaults: assert property (p_reset_defaults)
		else $error("config not default after reset");
	a_drive_table: assert property (p_drive_table)
		else $error("drive ohms mismatch");
	a_config_frozen: assert property (p_config_frozen)
		else $error("config changed during frame");
	a_dpd_entry: assert property (p_dpd_entry)
		else $error("deep power-down not entered");
	a_fixed_refresh: assert property (p_fixed_refresh)
		else $error("fixed latency strobe low");
	a_variable_refresh: assert property (p_variable_refresh)
		else $error("variable latency strobe wrong");
	a_oe_release: assert property (p_oe_release)
		else $error("outputs driven while deselected");
	a_wrap_stay: assert property (p_wrap_stay)
		else $error("wrap address left group");
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the configuration register and burst sequencer.
// Assumes the package, host model and checker are compiled first.
module tb_top;
	import pcb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] OHMS [8] = '{8'h22, 8'h73, 8'h43, 8'h2e, 8'h22,
		8'h1b, 8'h16, 8'h13};
	localparam logic [3:0] LCODE [6] = '{4'h0, 4'h1, 4'he, 4'hf, 4'he, 4'he};
	localparam logic LFIX [6] = '{0, 0, 0, 0, 1, 0};
	localparam logic LREF [6] = '{0, 0, 0, 0, 0, 1};
	localparam int LNUM [6] = '{5, 6, 3, 4, 6, 6};
	localparam int GWORDS [4] = '{64, 32, 8, 16};
	logic clock, resetn, refresh_pending, cs_n, link_ck;
	logic [7:0] host_dq, dq_in, dq_out, drive_ohms;
	logic dq_oe, read_write_data_strobe_in, read_write_data_strobe_out, read_write_data_strobe_oe, deep_power_down_state;
	logic [15:0] array_rdata = 16'h0;
	pcb_array_req_type array_req;
	pcb_config_type config_out;
	pcb_power_type power_state;
	int fails, n_checks;

	// The host never drives the strobe, so a released wire reads high.
	assign dq_in = dq_oe ? dq_out : host_dq;
	assign read_write_data_strobe_in = read_write_data_strobe_oe ? read_write_data_strobe_out : 1'b1;

	always @(posedge clock)
		if (array_req.read_strobe)
			array_rdata <= array_req.addr[15:0] ^ 16'ha5a5;

	pcb_sequencer i_pcb_sequencer (.clock(clock), .resetn(resetn),
		.cs_n(cs_n), .link_ck(link_ck), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .read_write_data_strobe_in(read_write_data_strobe_in), .read_write_data_strobe_out(read_write_data_strobe_out),
		.read_write_data_strobe_oe(read_write_data_strobe_oe), .refresh_pending(refresh_pending),
		.array_rdata(array_rdata), .array_req(array_req),
		.config_out(config_out), .drive_ohms(drive_ohms),
		.deep_power_down_state(deep_power_down_state),
		.power_state(power_state));
	pcb_host_model i_pcb_host_model (.clock(clock), .cs_n(cs_n),
		.link_ck(link_ck), .host_dq(host_dq), .dq_out(dq_out),
		.read_write_data_strobe_out(read_write_data_strobe_out));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	function automatic logic [15:0] w(input int i);
		return {i_pcb_host_model.got[i][7:0], i_pcb_host_model.got[i + 1][7:0]};
	endfunction
	function automatic logic [15:0] st(input int i);
		return {14'h0, i_pcb_host_model.got[i][8], i_pcb_host_model.got[i + 1][8]};
	endfunction

	task automatic wr_cfg(input logic [15:0] v);
		i_pcb_host_model.xfer(48'h600001000000, v, 2);
	endtask

	task automatic t_power();
		chk(config_out, PCB_CONFIG_RESET);
		chk({8'h0, drive_ohms}, 16'h22);
		wr_cfg(16'h0f1f);
		chk({15'h0, deep_power_down_state}, 16'h1);
		chk({14'h0, power_state}, {14'h0, PCB_PWR_DEEP_DOWN});
		i_pcb_host_model.cs_pulse();
		chk({15'h0, deep_power_down_state}, 16'h0);
		chk(config_out, PCB_CONFIG_RESET);
		$display("t_power done");
	endtask

	task automatic t_drive();
		logic [15:0] v;
		for (int d = 0; d < 8; d++) begin
			v = {1'b1, 3'(d), 12'hf1f};
			wr_cfg(v);
			chk(config_out, v);
			chk({8'h0, drive_ohms}, {8'h0, OHMS[d]});
		end
		$display("t_drive done");
	endtask

	task automatic t_latency();
		logic [15:0] v;
		int n;
		for (int k = 0; k < 6; k++) begin
			v = {8'h8f, LCODE[k], LFIX[k], 3'b111};
			refresh_pending <= LREF[k];
			wr_cfg(v);
			n = LNUM[k];
			i_pcb_host_model.xfer(48'hc00001000000, 16'h0, 2 * n + 4);
			chk(st(2 * n - 2), 16'h0);
			chk(st(2 * n), 16'h2);
			chk(w(2 * n), v);
			chk(w(2 * n + 2), v);
		end
		refresh_pending <= 1'b0;
		$display("t_latency done");
	endtask

	task automatic t_wrap();
		logic [31:0] a, m, e;
		int gw;
		a = 32'h12e;
		for (int k = 0; k < 8; k++) begin
			gw = GWORDS[k % 4];
			m = 32'(gw - 1);
			wr_cfg({8'h8f, 4'h1, 1'b0, 1'(k / 4), 2'(k % 4)});
			i_pcb_host_model.xfer({3'b100, a[31:3], 13'h0, a[2:0]}, 16'h0,
				12 + 2 * (gw + 4));
			for (int i = 0; i < gw + 4; i++) begin
				e = (a & ~m) | ((a + 32'(i)) & m);
				if (k < 4 && i >= gw)
					e = (a & ~m) + 32'(i);
				chk(w(12 + 2 * i), e[15:0] ^ 16'ha5a5);
			end
		end
		$display("t_wrap done");
	endtask

	initial begin
		resetn = 1'b0;
		refresh_pending = 1'b0;
		fails = 0;
		n_checks = 0;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		repeat (8) @(posedge clock);
		t_power();
		t_drive();
		t_latency();
		t_wrap();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		finish_test();
	end
endmodule

bind pcb_sequencer pcb_seq_assertions i_pcb_seq_assertions (.clock(clock),
	.resetn(resetn), .cs_n(cs_n), .refresh_pending(refresh_pending),
	.dq_oe(dq_oe), .read_write_data_strobe_out(read_write_data_strobe_out), .read_write_data_strobe_oe(read_write_data_strobe_oe),
	.array_req(array_req), .config_out(config_out),
	.drive_ohms(drive_ohms), .deep_power_down_state(deep_power_down_state));

// [verilog/pcb_pkg.sv]
// Shared constants and types for the configuration register and burst
// sequencer of a self-refreshing pseudo-static DRAM.
// Assumes one 20 MHz system clock and an asynchronous active-low reset.
package pcb_pkg;

	// Configuration word layout, most significant field first.
	typedef struct packed {
		logic normal_power;
		logic [2:0] drive_code;
		logic [3:0] reserved_ones;
		logic [3:0] latency_code;
		logic fixed_latency;
		logic legacy_wrap;
		logic [1:0] burst_length;
	} pcb_config_type;

	localparam logic [15:0] PCB_CONFIG_RESET = 16'h8f1f;
	localparam int PCB_CONFIG_WIDTH = 16;

	// Command/address word bit positions.
	localparam int PCB_CA_BYTES = 6;
	localparam int PCB_CA_READ = 47;
	localparam int PCB_CA_REGSPACE = 46;
	localparam int PCB_CA_LINEAR = 45;
	localparam int PCB_CA_UPPER_HI = 44;
	localparam int PCB_CA_UPPER_LO = 16;
	localparam int PCB_CA_LOWER_HI = 2;
	localparam int PCB_CA_REGSEL_HI = 31;
	localparam int PCB_CA_REGSEL_LO = 24;
	localparam int PCB_CA_REGIDX_HI = 7;
	localparam logic [7:0] PCB_REGSEL_CONFIG = 8'h01;
	localparam logic [7:0] PCB_REGIDX_PRIMARY = 8'h00;

	// Latency codes.
	localparam logic [3:0] PCB_LAT_5 = 4'h0;
	localparam logic [3:0] PCB_LAT_6 = 4'h1;
	localparam logic [3:0] PCB_LAT_3 = 4'he;
	localparam logic [3:0] PCB_LAT_4 = 4'hf;

	// Burst length codes.
	localparam logic [1:0] PCB_BL_128 = 2'h0;
	localparam logic [1:0] PCB_BL_64 = 2'h1;
	localparam logic [1:0] PCB_BL_16 = 2'h2;
	localparam logic [1:0] PCB_BL_32 = 2'h3;

	// Word-address span of each group minus one.
	localparam logic [5:0] PCB_MASK_128 = 6'h3f;
	localparam logic [5:0] PCB_MASK_64 = 6'h1f;
	localparam logic [5:0] PCB_MASK_16 = 6'h07;
	localparam logic [5:0] PCB_MASK_32 = 6'h0f;

	// Array word port towards the storage array.
	typedef struct packed {
		logic [31:0] addr;
		logic read_strobe;
		logic write_strobe;
		logic [15:0] wdata;
		logic [1:0] wmask;
	} pcb_array_req_type;

	typedef enum logic [1:0] {
		PCB_PWR_STANDBY,
		PCB_PWR_ACTIVE,
		PCB_PWR_DEEP_DOWN
	} pcb_power_type;

endpackage

// [verilog/pcb_sequencer.sv]
// Configuration register and burst address sequencer of the device end of
// an 8-bit double-data-rate command/address/data link.
// Assumes the link clock and pins are asynchronous and slow against clock
// (at least three clock cycles between link edges); the array port and the
// refresh request are on clock.
module pcb_sequencer
	import pcb_pkg::*;
#(
	parameter int ADDR_WIDTH = 22
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic link_ck,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic read_write_data_strobe_in,
	output logic read_write_data_strobe_out,
	output logic read_write_data_strobe_oe,
	input wire logic refresh_pending,
	input wire logic [15:0] array_rdata,
	output pcb_array_req_type array_req,
	output pcb_config_type config_out,
	output logic [7:0] drive_ohms,
	output logic deep_power_down_state,
	output pcb_power_type power_state
);

	initial begin
		if (ADDR_WIDTH < 7 || ADDR_WIDTH > 32)
			$error("ADDR_WIDTH must lie between 7 and 32");
	end

	typedef enum logic [2:0] {
		PCB_IDLE,
		PCB_CMD,
		PCB_LATENCY,
		PCB_REG_WRITE,
		PCB_DATA,
		PCB_HOLD
	} pcb_state_type;

	function automatic logic [3:0] latency_clocks(input logic [3:0] code);
		unique case (code)
			PCB_LAT_5: latency_clocks = 4'h5;
			PCB_LAT_3: latency_clocks = 4'h3;
			PCB_LAT_4: latency_clocks = 4'h4;
			// Reserved codes fall back to the slowest safe count.
			default: latency_clocks = 4'h6;
		endcase
	endfunction

	function automatic logic [5:0] group_mask(input logic [1:0] code);
		unique case (code)
			PCB_BL_128: group_mask = PCB_MASK_128;
			PCB_BL_64: group_mask = PCB_MASK_64;
			PCB_BL_16: group_mask = PCB_MASK_16;
			PCB_BL_32: group_mask = PCB_MASK_32;
		endcase
	endfunction

	// Three-stage synchronisers; a chip select or link clock change counts once stages
	// two and three agree, so the first stage feeds nothing but the second.
	logic [10:0] sync1_reg, sync2_reg, sync3_reg;
	logic cs_filt_reg, ck_filt_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// Link clock resets to its idle low level so that no false edge
			// is seen once reset lets go.
			sync1_reg <= 11'h400;
			sync2_reg <= 11'h400;
			sync3_reg <= 11'h400;
		end else begin
			sync1_reg <= {cs_n, link_ck, read_write_data_strobe_in, dq_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	logic cs_agree, ck_agree, cs_fall, cs_rise, ck_rise, ck_fall, ck_edge;
	logic [7:0] dq_s;
	logic read_write_data_strobe_s;
	assign cs_agree = sync2_reg[10] == sync3_reg[10];
	assign ck_agree = sync2_reg[9] == sync3_reg[9];
	assign cs_fall = cs_agree && cs_filt_reg && !sync3_reg[10];
	assign cs_rise = cs_agree && !cs_filt_reg && sync3_reg[10];
	assign ck_rise = ck_agree && !ck_filt_reg && sync3_reg[9] && !cs_filt_reg;
	assign ck_fall = ck_agree && ck_filt_reg && !sync3_reg[9] && !cs_filt_reg;
	assign ck_edge = ck_rise || ck_fall;
	assign read_write_data_strobe_s = sync3_reg[8];
	assign dq_s = sync3_reg[7:0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cs_filt_reg <= 1'b1;
			ck_filt_reg <= 1'b0;
		end else begin
			if (cs_agree)
				cs_filt_reg <= sync3_reg[10];
			if (ck_agree)
				ck_filt_reg <= sync3_reg[9];
		end
	end

	pcb_state_type state_reg;
	logic [2:0] ca_count_reg;
	logic [47:0] ca_reg;
	logic [47:0] ca_next;
	logic [4:0] lat_count_reg;
	logic double_lat_reg;
	logic dpd_reg;
	logic [15:0] cfg_reg;
	logic [15:0] pend_word_reg;
	logic pend_valid_reg;
	logic byte_lo_reg;
	logic [4:0] lat_total;
	logic is_read, is_reg, is_config, data_edge;
	pcb_config_type cfg;

	assign cfg = pcb_config_type'(cfg_reg);
	assign ca_next = {ca_reg[39:0], dq_s};
	assign is_read = ca_reg[PCB_CA_READ];
	assign is_reg = ca_reg[PCB_CA_REGSPACE];
	assign is_config = ca_reg[PCB_CA_REGSEL_HI:PCB_CA_REGSEL_LO]
		== PCB_REGSEL_CONFIG
		&& ca_reg[PCB_CA_REGIDX_HI:0] == PCB_REGIDX_PRIMARY;
	assign lat_total = double_lat_reg
		? {latency_clocks(cfg.latency_code), 1'b0}
		: {1'b0, latency_clocks(cfg.latency_code)};
	assign data_edge = (state_reg == PCB_DATA && ck_edge)
		|| (state_reg == PCB_LATENCY && ck_rise && lat_count_reg == lat_total);

	// Transaction sequencing.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= PCB_IDLE;
			ca_count_reg <= 3'h0;
			ca_reg <= 48'h0;
			lat_count_reg <= 5'h0;
			double_lat_reg <= 1'b0;
		end else if (cs_rise) begin
			state_reg <= PCB_IDLE;
		end else begin
			unique case (state_reg)
				PCB_IDLE: begin
					if (cs_fall && !dpd_reg) begin
						state_reg <= PCB_CMD;
						ca_count_reg <= 3'h0;
						lat_count_reg <= 5'h0;
						double_lat_reg <= cfg.fixed_latency || refresh_pending;
					end
				end
				PCB_CMD: begin
					if (ck_edge) begin
						ca_reg <= ca_next;
						ca_count_reg <= ca_count_reg + 3'h1;
						if (ca_count_reg == 3'(PCB_CA_BYTES - 1)) begin
							if (!ca_next[PCB_CA_READ] && ca_next[PCB_CA_REGSPACE])
								state_reg <= PCB_REG_WRITE;
							else
								state_reg <= PCB_LATENCY;
						end
					end
				end
				PCB_LATENCY: begin
					if (data_edge)
						state_reg <= PCB_DATA;
					else if (ck_rise)
						lat_count_reg <= lat_count_reg + 5'h1;
				end
				PCB_REG_WRITE: begin
					if (ck_fall)
						state_reg <= PCB_HOLD;
				end
				PCB_DATA, PCB_HOLD: begin
				end
			endcase
		end
	end

	// Register write capture; the word is committed when chip select rises so
	// the fields only change with the link back in standby.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pend_word_reg <= 16'h0;
			pend_valid_reg <= 1'b0;
		end else if (cs_rise || cs_fall) begin
			pend_valid_reg <= 1'b0;
		end else if (state_reg == PCB_REG_WRITE && ck_edge) begin
			if (ck_rise)
				pend_word_reg[15:8] <= dq_s;
			else begin
				pend_word_reg[7:0] <= dq_s;
				pend_valid_reg <= is_config;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg_reg <= PCB_CONFIG_RESET;
			dpd_reg <= 1'b0;
		end else if (cs_rise && dpd_reg) begin
			// The access that wakes the part leaves the power bit normal.
			dpd_reg <= 1'b0;
			cfg_reg[PCB_CONFIG_WIDTH - 1] <= 1'b1;
		end else if (cs_rise && pend_valid_reg) begin
			cfg_reg <= pend_word_reg;
			dpd_reg <= !pend_word_reg[PCB_CONFIG_WIDTH - 1];
		end
	end

	// Burst address generation.
	logic [ADDR_WIDTH-1:0] addr_reg, addr_mask, addr_base, addr_start;
	logic linear_reg;
	logic [5:0] wrap_left_reg;
	logic [31:0] ca_addr;
	assign ca_addr = {ca_reg[PCB_CA_UPPER_HI:PCB_CA_UPPER_LO],
		ca_reg[PCB_CA_LOWER_HI:0]};
	assign addr_start = ca_addr[ADDR_WIDTH-1:0];
	assign addr_mask = ADDR_WIDTH'(group_mask(cfg.burst_length));
	assign addr_base = addr_reg & ~addr_mask;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			addr_reg <= '0;
			linear_reg <= 1'b0;
			wrap_left_reg <= 6'h0;
		end else if (state_reg == PCB_CMD && ck_fall
				&& ca_count_reg == 3'(PCB_CA_BYTES - 1)) begin
			addr_reg <= '0;
			linear_reg <= 1'b0;
		end else if (state_reg == PCB_LATENCY && lat_count_reg == 5'h0) begin
			addr_reg <= addr_start;
			linear_reg <= ca_reg[PCB_CA_LINEAR] || is_reg;
			wrap_left_reg <= group_mask(cfg.burst_length);
		end else if (data_edge && byte_lo_reg) begin
			if (linear_reg) begin
				addr_reg <= addr_reg + ADDR_WIDTH'(1);
			end else if (wrap_left_reg == 6'h0 && !cfg.legacy_wrap) begin
				addr_reg <= addr_base + addr_mask + ADDR_WIDTH'(1);
				linear_reg <= 1'b1;
			end else begin
				addr_reg <= addr_base | ((addr_reg + ADDR_WIDTH'(1)) & addr_mask);
				wrap_left_reg <= wrap_left_reg - 6'h1;
			end
		end
	end

	// Data bytes, strobe and array requests.
	logic [15:0] read_word;
	assign read_word = is_reg ? (is_config ? cfg_reg : 16'h0) : array_rdata;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			byte_lo_reg <= 1'b0;
			dq_out <= 8'h0;
			dq_oe <= 1'b0;
			read_write_data_strobe_out <= 1'b0;
			read_write_data_strobe_oe <= 1'b0;
			array_req <= '0;
		end else begin
			array_req.read_strobe <= 1'b0;
			array_req.write_strobe <= 1'b0;
			if (cs_rise || state_reg == PCB_IDLE) begin
				byte_lo_reg <= 1'b0;
				dq_oe <= 1'b0;
				read_write_data_strobe_oe <= cs_fall && !dpd_reg;
				read_write_data_strobe_out <= cfg.fixed_latency || refresh_pending;
			end else if (state_reg == PCB_CMD && ck_fall
					&& ca_count_reg == 3'(PCB_CA_BYTES - 1)) begin
				read_write_data_strobe_oe <= ca_next[PCB_CA_READ];
				read_write_data_strobe_out <= 1'b0;
			end else if (state_reg == PCB_LATENCY && lat_count_reg == 5'h0
					&& ck_rise && !is_reg) begin
				// One request per frame start, at the first latency rise;
				// repeating it would look like a stuck address to the array.
				array_req.addr <= 32'(addr_start);
				array_req.read_strobe <= is_read;
			end else if (data_edge) begin
				byte_lo_reg <= !byte_lo_reg;
				if (is_read) begin
					dq_oe <= 1'b1;
					dq_out <= byte_lo_reg ? read_word[7:0] : read_word[15:8];
					read_write_data_strobe_out <= !byte_lo_reg;
				end else if (!byte_lo_reg) begin
					array_req.wdata[15:8] <= dq_s;
					array_req.wmask[1] <= read_write_data_strobe_s;
				end else begin
					array_req.wdata[7:0] <= dq_s;
					array_req.wmask[0] <= read_write_data_strobe_s;
					array_req.write_strobe <= !is_reg;
				end
				if (byte_lo_reg && is_read && !is_reg) begin
					array_req.read_strobe <= 1'b1;
					array_req.addr <= 32'(addr_next_word());
				end
			end
		end
	end

	function automatic logic [ADDR_WIDTH-1:0] addr_next_word();
		if (linear_reg)
			addr_next_word = addr_reg + ADDR_WIDTH'(1);
		else if (wrap_left_reg == 6'h0 && !cfg.legacy_wrap)
			addr_next_word = addr_base + addr_mask + ADDR_WIDTH'(1);
		else
			addr_next_word = addr_base
				| ((addr_reg + ADDR_WIDTH'(1)) & addr_mask);
	endfunction

	assign config_out = cfg;
	assign deep_power_down_state = dpd_reg;

	always_comb begin
		unique case (cfg.drive_code)
			3'h1: drive_ohms = 8'h73;
			3'h2: drive_ohms = 8'h43;
			3'h3: drive_ohms = 8'h2e;
			3'h5: drive_ohms = 8'h1b;
			3'h6: drive_ohms = 8'h16;
			3'h7: drive_ohms = 8'h13;
			default: drive_ohms = 8'h22;
		endcase
	end

	always_comb begin
		if (dpd_reg)
			power_state = PCB_PWR_DEEP_DOWN;
		else if (state_reg == PCB_IDLE)
			power_state = PCB_PWR_STANDBY;
		else
			power_state = PCB_PWR_ACTIVE;
	end

endmodule
